// File: rtl/crs_cfg.svh
// Constants for the core register set
// Overview of operation
// - One 8-bit working register holds arithmetic and logic operands and results.
// - Two 8-bit index registers serve indexed addressing and temporary data.
// - Second index register is never stacked on interrupt entry or return.
// - Program counter is 16 bits, handled as separate low and high bytes.
// - Flags are 8 bits, top three read one; reset sets interrupt mask.
// - Half carry is set on carry from bit 3 by add, cleared otherwise.
// - Interrupt mask set on entry and by instruction, cleared by instruction; trap ignores it.
// - Masked requests stay pending and are serviced once the mask clears.
// - Negative flag copies bit 7 of each arithmetic, logic or data result.
// - Zero flag is set when the last result is zero, cleared otherwise.
// - Carry shows last overflow; set, cleared, or changed by test, shift, rotate.
// - Flags can be pushed and popped; only carry and mask are individually controllable.
// - Stack pointer names next free byte; decrement after push, increment before pop.
// - Stack is 64 bytes; upper ten pointer bits fixed, reset value 013F.
// - Reset and the stack reload instruction set the six variable bits to ones.
// - Pointer wraps silently past either stack limit.
// - Six variable bits of the stack pointer are loadable from the low byte by the load instruction.
// - Interrupt stores program counter low byte first; call uses two bytes, interrupt five.
// - Core registers are not memory mapped; only dedicated operations reach them.
// - Interrupt entry stacks counter, first index, working register, flags, then sets mask.
// - Interrupts are taken only at an instruction boundary.
// - After reset the counter is loaded from the vector at FFFE and FFFF.
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH
`define CRS_FLAG_RST 8'he8
`define CRS_FLAG_ONES 3'h7
`define CRS_BIT_H 4
`define CRS_BIT_I 3
`define CRS_BIT_N 2
`define CRS_BIT_Z 1
`define CRS_BIT_C 0
`define CRS_SP_TOP 16'h013f
`define CRS_SP_VAR_W 6
`define CRS_VEC_HI 16'hfffe
`define CRS_VEC_LO 16'hffff
`define CRS_IDX_PC_LO 3'h0
`define CRS_IDX_PC_HI 3'h1
`define CRS_IDX_INDEX 3'h2
`define CRS_IDX_WORK 3'h3
`define CRS_IDX_FLAGS 3'h4
`endif

// File: rtl/crs_pkg.sv
// Types shared by the core register set
package crs_pkg;
    typedef enum logic [4:0] {
        CRS_OP_NONE = 5'h00,
        CRS_OP_ALU = 5'h01,
        CRS_OP_LDA = 5'h02,
        CRS_OP_LDX = 5'h03,
        CRS_OP_LDY = 5'h04,
        CRS_OP_CARRY = 5'h05,
        CRS_OP_CARRY_SET = 5'h06,
        CRS_OP_CARRY_CLR = 5'h07,
        CRS_OP_SIM = 5'h08,
        CRS_OP_RIM = 5'h09,
        CRS_OP_SP_RELOAD = 5'h0a,
        CRS_OP_SP_LOW = 5'h0b,
        CRS_OP_PUSH_FLAGS = 5'h0c,
        CRS_OP_POP_FLAGS = 5'h0d,
        CRS_OP_PC = 5'h0e,
        CRS_OP_CALL = 5'h0f,
        CRS_OP_RET = 5'h10,
        CRS_OP_TRAP = 5'h11,
        CRS_OP_INT_RET = 5'h12
    } crs_op_t;

    typedef enum logic [5:0] {
        CRS_S_RST_HI = 6'b000001,
        CRS_S_RST_LO = 6'b000010,
        CRS_S_IDLE = 6'b000100,
        CRS_S_PUSH = 6'b001000,
        CRS_S_POP = 6'b010000,
        CRS_S_DRAIN = 6'b100000
    } crs_state_t;
endpackage : crs_pkg

// File: rtl/crs_sp_if.sv
// Stack pointer control interface between core sequencer and pointer unit
`timescale 1ns/1ns
`default_nettype none
interface crs_sp_if;
    logic push;
    logic pop;
    logic reload;
    logic wr_low;
    logic [7:0] wdata;
    logic [15:0] sp;
    logic [15:0] sp_plus1;
    modport unit(input push, input pop, input reload, input wr_low, input wdata,
                 output sp, output sp_plus1);
    modport core(output push, output pop, output reload, output wr_low, output wdata,
                 input sp, input sp_plus1);
endinterface : crs_sp_if
`default_nettype wire

// File: rtl/crs_sp_unit.sv
// Stack pointer with fixed upper bits and wrapping variable bits
`timescale 1ns/1ns
`default_nettype none
`include "crs_cfg.svh"
module crs_sp_unit #(
    parameter int VAR_W = `CRS_SP_VAR_W
) (
    input wire logic clock, // Core clock
    input wire logic arst_n, // Async reset, active low
    crs_sp_if.unit spi // Pointer control
);
    localparam logic [15:0] TOP = `CRS_SP_TOP;
    logic [VAR_W-1:0] var_ff;

    // Low byte must stay loadable, so depth bits fit in one byte
    if (VAR_W < 1 || VAR_W > 8) begin : g_chk
        $error("crs_sp_unit: VAR_W out of range");
    end

    // Variable bits: reload, load, push decrement, pop increment
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            var_ff <= {VAR_W{1'b1}};
        end else if (spi.reload) begin
            var_ff <= {VAR_W{1'b1}};
        end else if (spi.wr_low) begin
            var_ff <= spi.wdata[VAR_W-1:0];
        end else if (spi.push) begin
            var_ff <= var_ff - 1'b1;
        end else if (spi.pop) begin
            var_ff <= var_ff + 1'b1;
        end
    end

    // Upper bits are hard wired to the stack page
    assign spi.sp = {TOP[15:VAR_W], var_ff};
    assign spi.sp_plus1 = {TOP[15:VAR_W], VAR_W'(var_ff + 1'b1)};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_push_dec;
        spi.push && !spi.reload && !spi.wr_low |=> var_ff == VAR_W'($past(var_ff) - 1'b1);
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

    property p_wrap_low;
        spi.push && !spi.reload && !spi.wr_low && var_ff == '0 |=> var_ff == {VAR_W{1'b1}};
    endproperty
    a_wrap_low: assert property (p_wrap_low) else $error("no wrap at lower limit");

    property p_reload;
        spi.reload |=> spi.sp == TOP;
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not reach top");
endmodule : crs_sp_unit
`default_nettype wire

// File: rtl/crs_regset.sv
// Core register set with flag update, stacking sequencer and interrupt latch
`timescale 1ns/1ns
`default_nettype none
`include "crs_cfg.svh"
module crs_regset (
    input wire logic clock, // Core clock, 250 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic op_valid, // Operation strobe, one cycle
    input wire crs_pkg::crs_op_t op_code, // Operation to apply
    input wire logic [7:0] op_data, // Result or load byte
    input wire logic [15:0] op_addr, // Next, call or trap address
    input wire logic op_half, // Adder carry out of bit 3
    input wire logic op_half_en, // Operation is add or add with carry
    input wire logic op_carry, // Carry or borrow from the ALU
    input wire logic op_carry_en, // Operation affects carry
    input wire logic instr_end, // Instruction boundary pulse
    input wire logic irq_req, // Maskable request pulse
    input wire logic [15:0] irq_vector, // Handler address of the winning request
    input wire logic [7:0] mem_rdata, // Stack read data, cycle after read strobe
    output logic [7:0] accumulator, // Working register
    output logic [7:0] index_first, // First index register
    output logic [7:0] index_second, // Second index register
    output logic [15:0] program_counter, // Next instruction address
    output logic [7:0] flag_register, // Flags, top three bits one
    output logic [15:0] stack_pointer, // Next free stack byte
    output logic irq_pending, // Request waiting for service
    output logic busy, // Sequencer owns the stack, hold operations
    output logic mem_rd, // Stack read strobe
    output logic mem_wr, // Stack write strobe
    output logic [15:0] mem_addr, // Stack address
    output logic [7:0] mem_wdata // Stack write data
);
    crs_pkg::crs_state_t state_ff;
    logic [7:0] acc_ff, idx1_ff, idx2_ff, flag_ff, mem_wdata_ff;
    logic [15:0] pc_ff, vec_ff, mem_addr_ff;
    logic [2:0] cur_ff, end_ff, rd_idx_ff, cap_idx_ff;
    logic mem_rd_ff, mem_wr_ff, cap_vld_ff, pend_ff, vec_en_ff, int_ff, busy_ff;
    logic idle, take_irq, start_push, start_pop, nxt_vec_en, nxt_int;
    logic [2:0] nxt_from, nxt_to;
    logic [15:0] nxt_vec;
    logic [7:0] push_byte;
    logic push_last, pop_last, cap_flags;
    crs_sp_if spi();

    crs_sp_unit #(.VAR_W(`CRS_SP_VAR_W)) u_sp (
        .clock(clock),
        .arst_n(arst_n),
        .spi(spi)
    );

    // Ops act only while idle; requests wait for a boundary and a clear mask
    assign idle = (state_ff == crs_pkg::CRS_S_IDLE);
    assign take_irq = idle && !op_valid && instr_end && pend_ff && !flag_ff[`CRS_BIT_I];
    assign push_last = (cur_ff == end_ff);
    assign pop_last = (cur_ff == end_ff);
    assign cap_flags = cap_vld_ff && (cap_idx_ff == `CRS_IDX_FLAGS);

    // Decode the start of a stacking sequence
    always_comb begin
        start_push = 1'b0;
        start_pop = 1'b0;
        nxt_from = `CRS_IDX_PC_LO;
        nxt_to = `CRS_IDX_FLAGS;
        nxt_vec_en = 1'b0;
        nxt_int = 1'b0;
        nxt_vec = op_addr;
        if (idle && op_valid) begin
            unique case (op_code)
                crs_pkg::CRS_OP_CALL: begin
                    start_push = 1'b1;
                    nxt_to = `CRS_IDX_PC_HI;
                    nxt_vec_en = 1'b1;
                end
                crs_pkg::CRS_OP_TRAP: begin
                    start_push = 1'b1;
                    nxt_vec_en = 1'b1;
                    nxt_int = 1'b1;
                end
                crs_pkg::CRS_OP_PUSH_FLAGS: begin
                    start_push = 1'b1;
                    nxt_from = `CRS_IDX_FLAGS;
                end
                crs_pkg::CRS_OP_RET: begin
                    start_pop = 1'b1;
                    nxt_from = `CRS_IDX_PC_HI;
                    nxt_to = `CRS_IDX_PC_LO;
                end
                crs_pkg::CRS_OP_INT_RET: begin
                    start_pop = 1'b1;
                    nxt_from = `CRS_IDX_FLAGS;
                    nxt_to = `CRS_IDX_PC_LO;
                end
                crs_pkg::CRS_OP_POP_FLAGS: begin
                    start_pop = 1'b1;
                    nxt_from = `CRS_IDX_FLAGS;
                    nxt_to = `CRS_IDX_FLAGS;
                end
                default: begin
                end
            endcase
        end else if (take_irq) begin
            start_push = 1'b1;
            nxt_vec_en = 1'b1;
            nxt_int = 1'b1;
            nxt_vec = irq_vector;
        end
    end

    // Context byte for the current push slot; second index has no slot
    always_comb begin
        unique case (cur_ff)
            `CRS_IDX_PC_LO: push_byte = pc_ff[7:0];
            `CRS_IDX_PC_HI: push_byte = pc_ff[15:8];
            `CRS_IDX_INDEX: push_byte = idx1_ff;
            `CRS_IDX_WORK: push_byte = acc_ff;
            default: push_byte = flag_ff;
        endcase
    end

    // Sequencer: reset vector fetch, push and pop walks, read drain
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= crs_pkg::CRS_S_RST_HI;
            busy_ff <= 1'b1;
            cur_ff <= `CRS_IDX_PC_LO;
            end_ff <= `CRS_IDX_PC_LO;
            vec_ff <= `CRS_VEC_HI;
            vec_en_ff <= 1'b0;
            int_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                crs_pkg::CRS_S_RST_HI: state_ff <= crs_pkg::CRS_S_RST_LO;
                crs_pkg::CRS_S_RST_LO: state_ff <= crs_pkg::CRS_S_DRAIN;
                crs_pkg::CRS_S_IDLE: begin
                    if (start_push || start_pop) begin
                        state_ff <= start_push ? crs_pkg::CRS_S_PUSH : crs_pkg::CRS_S_POP;
                        busy_ff <= 1'b1;
                        cur_ff <= nxt_from;
                        end_ff <= nxt_to;
                        vec_ff <= nxt_vec;
                        vec_en_ff <= nxt_vec_en;
                        int_ff <= nxt_int;
                    end
                end
                crs_pkg::CRS_S_PUSH: begin
                    cur_ff <= 3'(cur_ff + 1'b1);
                    if (push_last) begin
                        state_ff <= crs_pkg::CRS_S_IDLE;
                        busy_ff <= 1'b0;
                    end
                end
                crs_pkg::CRS_S_POP: begin
                    cur_ff <= 3'(cur_ff - 1'b1);
                    if (pop_last) begin
                        state_ff <= crs_pkg::CRS_S_DRAIN;
                    end
                end
                crs_pkg::CRS_S_DRAIN: begin
                    if (!mem_rd_ff && !cap_vld_ff) begin
                        state_ff <= crs_pkg::CRS_S_IDLE;
                        busy_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Stack memory strobes, address and data, plus read capture pipeline
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            mem_addr_ff <= `CRS_VEC_HI;
            mem_wdata_ff <= 8'h00;
            rd_idx_ff <= `CRS_IDX_PC_LO;
            cap_vld_ff <= 1'b0;
            cap_idx_ff <= `CRS_IDX_PC_LO;
        end else begin
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            cap_vld_ff <= mem_rd_ff;
            cap_idx_ff <= rd_idx_ff;
            if (state_ff == crs_pkg::CRS_S_RST_HI || state_ff == crs_pkg::CRS_S_RST_LO) begin
                mem_rd_ff <= 1'b1;
                mem_addr_ff <= state_ff[0] ? `CRS_VEC_HI : `CRS_VEC_LO;
                rd_idx_ff <= state_ff[0] ? `CRS_IDX_PC_HI : `CRS_IDX_PC_LO;
            end else if (state_ff == crs_pkg::CRS_S_PUSH) begin
                mem_wr_ff <= 1'b1;
                mem_addr_ff <= spi.sp;
                mem_wdata_ff <= push_byte;
            end else if (state_ff == crs_pkg::CRS_S_POP) begin
                mem_rd_ff <= 1'b1;
                mem_addr_ff <= spi.sp_plus1;
                rd_idx_ff <= cur_ff;
            end
        end
    end

    // Pointer steps: decrement after each write, increment before each read
    assign spi.push = (state_ff == crs_pkg::CRS_S_PUSH);
    assign spi.pop = (state_ff == crs_pkg::CRS_S_POP);
    assign spi.reload = idle && op_valid && (op_code == crs_pkg::CRS_OP_SP_RELOAD);
    assign spi.wr_low = idle && op_valid && (op_code == crs_pkg::CRS_OP_SP_LOW);
    assign spi.wdata = op_data;

    // Pending latch: a new request wins over the clear by service
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= irq_req || (pend_ff && !take_irq);
        end
    end

    // Working and index registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_ff <= 8'h00;
            idx1_ff <= 8'h00;
            idx2_ff <= 8'h00;
        end else if (cap_vld_ff) begin
            if (cap_idx_ff == `CRS_IDX_WORK) acc_ff <= mem_rdata;
            if (cap_idx_ff == `CRS_IDX_INDEX) idx1_ff <= mem_rdata;
        end else if (idle && op_valid) begin
            if (op_code == crs_pkg::CRS_OP_ALU || op_code == crs_pkg::CRS_OP_LDA) begin
                acc_ff <= op_data;
            end
            if (op_code == crs_pkg::CRS_OP_LDX) idx1_ff <= op_data;
            if (op_code == crs_pkg::CRS_OP_LDY) idx2_ff <= op_data;
        end
    end

    // Program counter, loaded by halves from the stack or vector memory
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pc_ff <= 16'h0000;
        end else if (cap_vld_ff) begin
            if (cap_idx_ff == `CRS_IDX_PC_LO) pc_ff[7:0] <= mem_rdata;
            if (cap_idx_ff == `CRS_IDX_PC_HI) pc_ff[15:8] <= mem_rdata;
        end else if (state_ff == crs_pkg::CRS_S_PUSH && push_last && vec_en_ff) begin
            pc_ff <= vec_ff;
        end else if (idle && op_valid && op_code == crs_pkg::CRS_OP_PC) begin
            pc_ff <= op_addr;
        end
    end

    // Flags: result driven N and Z, adder H, carry and mask controls
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flag_ff <= `CRS_FLAG_RST;
        end else if (cap_flags) begin
            flag_ff <= {`CRS_FLAG_ONES, mem_rdata[4:0]};
        end else if (state_ff == crs_pkg::CRS_S_PUSH && push_last && int_ff) begin
            flag_ff[`CRS_BIT_I] <= 1'b1;
        end else if (idle && op_valid) begin
            unique case (op_code)
                crs_pkg::CRS_OP_ALU, crs_pkg::CRS_OP_LDA, crs_pkg::CRS_OP_LDX,
                crs_pkg::CRS_OP_LDY: begin
                    flag_ff[`CRS_BIT_N] <= op_data[7];
                    flag_ff[`CRS_BIT_Z] <= (op_data == 8'h00);
                    if (op_half_en) flag_ff[`CRS_BIT_H] <= op_half;
                    if (op_carry_en) flag_ff[`CRS_BIT_C] <= op_carry;
                end
                crs_pkg::CRS_OP_CARRY: flag_ff[`CRS_BIT_C] <= op_carry;
                crs_pkg::CRS_OP_CARRY_SET: flag_ff[`CRS_BIT_C] <= 1'b1;
                crs_pkg::CRS_OP_CARRY_CLR: flag_ff[`CRS_BIT_C] <= 1'b0;
                crs_pkg::CRS_OP_SIM: flag_ff[`CRS_BIT_I] <= 1'b1;
                crs_pkg::CRS_OP_RIM: flag_ff[`CRS_BIT_I] <= 1'b0;
                default: begin
                end
            endcase
        end
    end

    // Outputs straight from registers; none of them is memory mapped
    assign accumulator = acc_ff;
    assign index_first = idx1_ff;
    assign index_second = idx2_ff;
    assign program_counter = pc_ff;
    assign flag_register = flag_ff;
    assign stack_pointer = spi.sp;
    assign irq_pending = pend_ff;
    assign busy = busy_ff;
    assign mem_rd = mem_rd_ff;
    assign mem_wr = mem_wr_ff;
    assign mem_addr = mem_addr_ff;
    assign mem_wdata = mem_wdata_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_irq_start;
        take_irq;
    endsequence
    sequence s_five_writes;
        (mem_wr_ff && mem_wdata_ff == $past(pc_ff[7:0], 2)) ##1 mem_wr_ff [*4] ##1 !mem_wr_ff;
    endsequence

    property p_ones;
        flag_ff[7:5] == `CRS_FLAG_ONES;
    endproperty
    a_ones: assert property (p_ones) else $error("flag upper bits not one");

    property p_half;
        idle && op_valid && op_code == crs_pkg::CRS_OP_ALU && op_half_en
            |=> flag_ff[`CRS_BIT_H] == $past(op_half);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");

    property p_neg_zero;
        idle && op_valid && op_code == crs_pkg::CRS_OP_ALU |=> flag_ff[`CRS_BIT_N] ==
            $past(op_data[7]) && flag_ff[`CRS_BIT_Z] == ($past(op_data) == 8'h00);
    endproperty
    a_neg_zero: assert property (p_neg_zero) else $error("sign or zero flag wrong");

    property p_mask_blocks;
        idle && pend_ff && flag_ff[`CRS_BIT_I] && !op_valid |=> state_ff != crs_pkg::CRS_S_PUSH;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked request taken");

    property p_irq_stack;
        s_irq_start |-> ##2 s_five_writes;
    endproperty
    a_irq_stack: assert property (p_irq_stack) else $error("interrupt did not stack five");

    property p_irq_vec;
        s_irq_start |-> ##6 flag_ff[`CRS_BIT_I] && pc_ff == $past(irq_vector, 6);
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("entry mask or vector wrong");

    property p_y_kept;
        !idle |=> $stable(idx2_ff);
    endproperty
    a_y_kept: assert property (p_y_kept) else $error("second index changed");

    property p_carry_set;
        idle && op_valid && op_code == crs_pkg::CRS_OP_CARRY_SET |=> flag_ff[`CRS_BIT_C];
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry not set");
endmodule : crs_regset
`default_nettype wire

// File: test/crs_regset_test.sv
// Self-checking bench for the core register set
`timescale 1ns/1ns
`default_nettype none
module crs_regset_test;
    logic clock = 1'b0, arst_n = 1'b0, op_valid = 1'b0, op_half = 1'b0, op_half_en = 1'b0;
    logic op_carry = 1'b0, op_carry_en = 1'b0, instr_end = 1'b0, irq_req = 1'b0;
    crs_pkg::crs_op_t op_code = crs_pkg::CRS_OP_NONE;
    logic [7:0] op_data = 8'h00, mem_rdata = 8'h00, accumulator, index_first, index_second;
    logic [7:0] flag_register, mem_wdata;
    logic [15:0] op_addr = 16'h0000, irq_vector = 16'h4000, program_counter, stack_pointer;
    logic [15:0] mem_addr;
    logic irq_pending, busy, mem_rd, mem_wr;
    logic [7:0] stk [64];
    logic [23:0] wlog [$];
    int failures = 0, tests_run = 0;
    crs_regset uut (.clock(clock), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
        .op_data(op_data), .op_addr(op_addr), .op_half(op_half), .op_half_en(op_half_en),
        .op_carry(op_carry), .op_carry_en(op_carry_en), .instr_end(instr_end),
        .irq_req(irq_req), .irq_vector(irq_vector), .mem_rdata(mem_rdata),
        .accumulator(accumulator), .index_first(index_first), .index_second(index_second),
        .program_counter(program_counter), .flag_register(flag_register),
        .stack_pointer(stack_pointer), .irq_pending(irq_pending), .busy(busy),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    // Clock of 4 ns period
    initial begin
        forever #2 clock = ~clock;
    end
    // Stack memory and vector, answering the cycle after a read strobe
    always @(posedge clock) begin
        if (mem_wr) begin
            stk[mem_addr[5:0]] <= mem_wdata;
            wlog.push_back({mem_addr, mem_wdata});
        end
        if (mem_rd) begin
            mem_rdata <= (mem_addr == 16'hfffe) ? 8'h12 :
                         (mem_addr == 16'hffff) ? 8'h34 : stk[mem_addr[5:0]];
        end else begin
            mem_rdata <= ~mem_rdata; // Stale data never looks valid
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // Bounded wait until the sequencer lets go of the stack
    task automatic settle;
        int n;
        n = 0;
        repeat (2) @(posedge clock);
        #1;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        // The last stack strobe reaches the memory model one edge after busy falls
        @(posedge clock);
        #1;
        if (n == 40) begin
            failures++;
            $display("[FAIL] busy expected 0 seen %b", busy);
            complete_run();
        end
    endtask : settle
    task automatic op(input crs_pkg::crs_op_t c, input logic [7:0] d, input logic [15:0] a);
        @(posedge clock);
        op_valid <= 1'b1;
        op_code <= c;
        op_data <= d;
        op_addr <= a;
        @(posedge clock);
        op_valid <= 1'b0;
        settle();
    endtask : op
    // One-cycle request pulse, or an instruction boundary pulse
    task automatic strobe(input logic irq);
        @(posedge clock);
        irq_req <= irq;
        instr_end <= ~irq;
        @(posedge clock);
        irq_req <= 1'b0;
        instr_end <= 1'b0;
        settle();
    endtask : strobe
    task automatic t_flags;
        op_half <= 1'b1;
        op_half_en <= 1'b1;
        op_carry <= 1'b1;
        op_carry_en <= 1'b1;
        op(crs_pkg::CRS_OP_ALU, 8'h80, 16'h0000);
        chk("flags add", 16'h00fd, flag_register);
        op_half <= 1'b0;
        op_carry <= 1'b0;
        op(crs_pkg::CRS_OP_ALU, 8'h00, 16'h0000);
        chk("flags zero", 16'h00ea, flag_register);
        op_half_en <= 1'b0;
        op_carry_en <= 1'b0;
        op(crs_pkg::CRS_OP_CARRY_SET, 8'h00, 16'h0000);
        chk("carry set", 16'h00eb, flag_register);
        op(crs_pkg::CRS_OP_CARRY_CLR, 8'h00, 16'h0000);
        op(crs_pkg::CRS_OP_RIM, 8'h00, 16'h0000);
        chk("mask clear", 16'h00e2, flag_register);
        op(crs_pkg::CRS_OP_SIM, 8'h00, 16'h0000);
        op(crs_pkg::CRS_OP_LDA, 8'haa, 16'h0000);
        op(crs_pkg::CRS_OP_LDX, 8'h55, 16'h0000);
        op(crs_pkg::CRS_OP_LDY, 8'hf7, 16'h0000);
        chk("flags load", 16'h00ec, flag_register);
    endtask : t_flags
    task automatic t_intr;
        logic [7:0] ctx [5] = '{8'h34, 8'h12, 8'h55, 8'haa, 8'he4};
        strobe(1'b1);
        strobe(1'b0);
        chk("pending masked", 16'h0001, irq_pending);
        chk("masked writes", 16'h0000, 16'(wlog.size()));
        op(crs_pkg::CRS_OP_RIM, 8'h00, 16'h0000);
        strobe(1'b0);
        chk("entry writes", 16'h0005, 16'(wlog.size()));
        for (int i = 0; i < 5; i++) begin
            chk("entry addr", 16'h013f - i[15:0], wlog[i][23:8]);
            chk("entry byte", ctx[i], wlog[i][7:0]);
        end
        chk("vector", 16'h4000, program_counter);
        chk("entry flags", 16'h00ec, flag_register);
        chk("entry ptr", 16'h013a, stack_pointer);
        chk("pending served", 16'h0000, irq_pending);
        op(crs_pkg::CRS_OP_LDA, 8'h01, 16'h0000);
        op(crs_pkg::CRS_OP_LDX, 8'h02, 16'h0000);
        op(crs_pkg::CRS_OP_INT_RET, 8'h00, 16'h0000);
        chk("ret acc", 16'h00aa, accumulator);
        chk("ret idx", 16'h0055, index_first);
        chk("ret idx2", 16'h00f7, index_second);
        chk("ret counter", 16'h1234, program_counter);
        chk("ret flags", 16'h00e4, flag_register);
        chk("ret ptr", 16'h013f, stack_pointer);
    endtask : t_intr
    task automatic t_wrap;
        wlog.delete();
        op(crs_pkg::CRS_OP_SP_LOW, 8'h00, 16'h0000);
        chk("low load", 16'h0100, stack_pointer);
        op(crs_pkg::CRS_OP_SP_RELOAD, 8'h00, 16'h0000);
        chk("reload", 16'h013f, stack_pointer);
        op(crs_pkg::CRS_OP_SP_LOW, 8'h00, 16'h0000);
        op(crs_pkg::CRS_OP_CALL, 8'h00, 16'h2000);
        chk("call addr0", 16'h0100, wlog[0][23:8]);
        chk("call byte0", 16'h0034, wlog[0][7:0]);
        chk("call addr1", 16'h013f, wlog[1][23:8]);
        chk("call ptr", 16'h013e, stack_pointer);
        chk("call target", 16'h2000, program_counter);
        op(crs_pkg::CRS_OP_RET, 8'h00, 16'h0000);
        chk("ret target", 16'h1234, program_counter);
        chk("ret wrap", 16'h0100, stack_pointer);
    endtask : t_wrap
    // Carry load, jump, single flag push and pop, trap under a set mask
    task automatic t_misc;
        op_carry <= 1'b1;
        op(crs_pkg::CRS_OP_CARRY, 8'h00, 16'h0000);
        chk("carry op", 16'h00e5, flag_register);
        op(crs_pkg::CRS_OP_PC, 8'h00, 16'h5678);
        chk("next addr", 16'h5678, program_counter);
        op(crs_pkg::CRS_OP_PUSH_FLAGS, 8'h00, 16'h0000);
        chk("push ptr", 16'h013f, stack_pointer);
        op(crs_pkg::CRS_OP_CARRY_CLR, 8'h00, 16'h0000);
        op(crs_pkg::CRS_OP_POP_FLAGS, 8'h00, 16'h0000);
        chk("pop flags", 16'h00e5, flag_register);
        op(crs_pkg::CRS_OP_SIM, 8'h00, 16'h0000);
        op(crs_pkg::CRS_OP_TRAP, 8'h00, 16'h6000);
        chk("trap target", 16'h6000, program_counter);
        chk("trap ptr", 16'h013b, stack_pointer);
    endtask : t_misc
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        chk("reset flags", 16'h00e8, flag_register);
        chk("reset ptr", 16'h013f, stack_pointer);
        arst_n <= 1'b1;
        settle();
        chk("reset vector", 16'h1234, program_counter);
        t_flags();
        t_intr();
        t_wrap();
        t_misc();
        complete_run();
    end
endmodule : crs_regset_test
`default_nettype wire
